/* core/cbf_pkg.sv */
// Constants and types shared by the CAN buffer and filter register block
package cbf_pkg;

    // Functional modes of the controller
    typedef enum logic [1:0] {
        CBF_MODE0 = 2'b00,
        CBF_MODE1 = 2'b01,
        CBF_MODE2 = 2'b10
    } cbf_mode_e;

    // Sizes
    localparam int NUM_BUF = 6;
    localparam int NUM_FILT = 16;
    localparam int NUM_FILT_BASE = 6;
    localparam int NUM_DATA = 8;

    // Global register byte addresses
    localparam logic [11:0] OFF_MODE = 12'h000;
    localparam logic [11:0] OFF_BSEL = 12'h004;

    // Buffer window: base, end and offsets within one buffer
    localparam logic [11:0] BUF_BASE = 12'h100;
    localparam logic [11:0] BUF_END = 12'h280;
    localparam logic [5:0] BOFF_EIDH = 6'h00;
    localparam logic [5:0] BOFF_EIDL = 6'h04;
    localparam logic [5:0] BOFF_DATA0 = 6'h08;
    localparam logic [5:0] BOFF_DATA7 = 6'h24;
    localparam logic [5:0] BOFF_LEN = 6'h28;
    localparam logic [5:0] BOFF_CTRL = 6'h2c;

    // Filter window: base, end and offsets within one filter
    localparam logic [11:0] FILT_BASE = 12'h400;
    localparam logic [11:0] FILT_END = 12'h500;
    localparam logic [3:0] FOFF_SIDH = 4'h0;
    localparam logic [3:0] FOFF_SIDL = 4'h4;
    localparam logic [3:0] FOFF_EIDH = 4'h8;

    // Field positions
    localparam int BSEL_DIR_LSB = 2;
    localparam int LEN_REMOTE_BIT = 6;
    localparam int CTRL_REQ_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam int SIDL_EXT_SEL_BIT = 3;

    // Reset values and code limits
    localparam logic [5:0] BSEL_RESET = 6'h00;
    localparam logic [3:0] DLC_MAX = 4'h8;
endpackage

/* core/cbf_ahb_front.sv */
// AHB-Lite slave front end: zero-wait register read and write strobes
`timescale 1ns/1ps
module cbf_ahb_front (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic wr_en,
    output logic [11:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data
);
    logic pend_wr;
    logic pend_rd;
    logic [11:0] pend_addr;

    // Only whole-word NONSEQ or SEQ transfers are taken
    wire take = hsel && htrans[1] && hready && (hsize == 3'b010);

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_wr <= 1'b0;
            pend_rd <= 1'b0;
            pend_addr <= 12'h000;
        end else if (hready) begin
            pend_wr <= take && hwrite;
            pend_rd <= take && !hwrite;
            pend_addr <= haddr[11:0];
        end
    end

    // Data phase strobes, always OKAY and never stalled
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = pend_wr;
    assign wr_addr = pend_addr;
    assign wr_data = hwdata[7:0];
    assign rd_addr = pend_addr;
    assign hrdata = pend_rd ? rd_data : 32'h0000_0000;
endmodule // cbf_ahb_front

/* core/cbf_filter_bank.sv */
// Sixteen acceptance filter identifier registers
`timescale 1ns/1ps
module cbf_filter_bank (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic mode_ok,
    input wire logic wr_en,
    input wire logic [11:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [11:0] rd_addr,
    input wire logic frame_extended,
    output logic rd_hit,
    output logic [7:0] rd_byte,
    output logic [15:0] filt_ext_sel,
    output logic [15:0] filt_present,
    output logic [15:0] filt_type_ok
);
    logic [7:0] f_sidh [cbf_pkg::NUM_FILT];
    logic [4:0] f_sidl [cbf_pkg::NUM_FILT];
    logic [7:0] f_eidh [cbf_pkg::NUM_FILT];

    function automatic logic f_hit(input logic [11:0] a);
        return (a >= cbf_pkg::FILT_BASE) && (a < cbf_pkg::FILT_END);
    endfunction

    // [RL14] Upper filters only in modes 1 and 2
    always_comb begin
        for (int i = 0; i < cbf_pkg::NUM_FILT; i++) begin
            filt_present[i] = mode_ok || (i < cbf_pkg::NUM_FILT_BASE);
        end
    end

    wire [3:0] w_idx = wr_addr[7:4];
    wire w_ok = wr_en && f_hit(wr_addr) && filt_present[w_idx];
    wire [3:0] r_idx = rd_addr[7:4];
    assign rd_hit = f_hit(rd_addr);

    // [RL10] [RL11] [RL15] Identifier storage
    always_ff @(posedge hclk) begin
        if (w_ok && wr_addr[3:0] == cbf_pkg::FOFF_SIDH) f_sidh[w_idx] <= wr_data;
        if (w_ok && wr_addr[3:0] == cbf_pkg::FOFF_SIDL)
            f_sidl[w_idx] <= {wr_data[7:5], wr_data[1:0]};
        if (w_ok && wr_addr[3:0] == cbf_pkg::FOFF_EIDH) f_eidh[w_idx] <= wr_data;
    end

    // [RL12] Extended-select flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_ext_sel <= 16'h0000;
        end else if (w_ok && wr_addr[3:0] == cbf_pkg::FOFF_SIDL) begin
            filt_ext_sel[w_idx] <= wr_data[cbf_pkg::SIDL_EXT_SEL_BIT];
        end
    end

    // [RL12] Frame type acceptance per filter
    assign filt_type_ok = filt_present & (frame_extended ? filt_ext_sel : ~filt_ext_sel);

    // [RL11] Low byte packs with bits 4 and 2 zero
    wire [7:0] sidl_view = {f_sidl[r_idx][4:2], 1'b0, filt_ext_sel[r_idx], 1'b0,
                            f_sidl[r_idx][1:0]};
    assign rd_byte = !(rd_hit && filt_present[r_idx]) ? 8'h00 :
                     (rd_addr[3:0] == cbf_pkg::FOFF_SIDH) ? f_sidh[r_idx] :
                     (rd_addr[3:0] == cbf_pkg::FOFF_SIDL) ? sidl_view :
                     (rd_addr[3:0] == cbf_pkg::FOFF_EIDH) ? f_eidh[r_idx] : 8'h00;

    property p_filt_sidl_gaps;
        @(posedge hclk) disable iff (!hresetn)
        (rd_hit && rd_addr[3:0] == cbf_pkg::FOFF_SIDL)
            |-> (rd_byte[4] == 1'b0 && rd_byte[2] == 1'b0);
    endproperty
    a_filt_sidl_gaps: assert property (p_filt_sidl_gaps) // [RL11]
        else $error("filter low byte gap bits set");

    property p_filt_upper_absent;
        @(posedge hclk) disable iff (!hresetn)
        (!mode_ok && rd_hit && r_idx >= 4'h6) |-> (rd_byte == 8'h00);
    endproperty
    a_filt_upper_absent: assert property (p_filt_upper_absent) // [RL14]
        else $error("upper filter seen in mode 0");

    property p_filt_type;
        @(posedge hclk) disable iff (!hresetn)
        (w_ok && wr_addr[3:0] == cbf_pkg::FOFF_SIDL)
            |=> (filt_type_ok[$past(w_idx)] == (frame_extended == $past(wr_data[3])));
    endproperty
    a_filt_type: assert property (p_filt_type) // [RL12]
        else $error("filter type selection wrong");
endmodule // cbf_filter_bank

/* core/cbf_top.sv */
// CAN message buffer and acceptance filter register block on AHB-Lite
// Functional notes
// [RL1] Bits 7-2 select transmit per buffer; 1-0 zero
// [RL2] Buffer registers exist only in modes 1, 2
// [RL3] Data bytes read-only receiving, writable transmitting
// [RL4] Extended identifier bytes follow same access split
// [RL5] Receive stores remote flag in length bit 6
// [RL6] Receive length bits 7, 5, 4 read zero
// [RL7] Length codes above eight are reserved
// [RL8] Transmit length bit 6 drives remote flag
// [RL9] Transmit length: only remote and code writable
// [RL10] Filter high byte holds upper identifier bits
// [RL11] Filter low byte packing, bits 4, 2 zero
// [RL12] Filter bit 3 selects extended or standard frames
// [RL13] Mode 0 software sets filter select explicitly
// [RL14] Filters 6 to 15 only in modes 1, 2
// [RL15] Filter extended middle byte is read/write
// [RL16] Buffer extended flag marks extended frame
// [RL17] Pending or busy transmit buffer is read-only; the control request bit stays writable while pending or busy
// [RL18] Buffer contents have no reset value
`timescale 1ns/1ps
module cbf_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_store,
    input wire logic [2:0] rx_buf,
    input wire logic [15:0] rx_ext_id,
    input wire logic [63:0] rx_data,
    input wire logic [3:0] rx_dlc,
    input wire logic rx_remote,
    input wire logic rx_extended,
    input wire logic [5:0] tx_busy,
    input wire logic [5:0] tx_done,
    input wire logic [2:0] tx_sel,
    output logic [5:0] transmit_request,
    output logic [15:0] tx_ext_id,
    output logic [63:0] tx_data,
    output logic [3:0] tx_dlc,
    output logic [3:0] tx_byte_count,
    output logic tx_remote,
    output logic tx_extended,
    output logic [15:0] filt_ext_sel,
    output logic [15:0] filt_type_ok
);
    cbf_pkg::cbf_mode_e mode;
    logic [5:0] buffer_tx_direction_bits;
    logic [5:0] next_transmit_request;

    // Buffer contents, deliberately without reset
    logic [7:0] buf_eid_hi [cbf_pkg::NUM_BUF];
    logic [7:0] buf_eid_lo [cbf_pkg::NUM_BUF];
    logic [7:0] buf_data [cbf_pkg::NUM_BUF][cbf_pkg::NUM_DATA];
    logic [3:0] buf_dlc [cbf_pkg::NUM_BUF];
    logic buf_remote [cbf_pkg::NUM_BUF];
    logic buf_extended [cbf_pkg::NUM_BUF];

    logic wr_en;
    logic [11:0] wr_addr;
    logic [7:0] wr_data;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic f_hit;
    logic [7:0] f_byte;
    logic [15:0] filt_present;

    // Address inside the buffer window
    function automatic logic buf_hit(input logic [11:0] a);
        return (a >= cbf_pkg::BUF_BASE) && (a < cbf_pkg::BUF_END);
    endfunction

    // Buffer number from an address in the window
    function automatic logic [2:0] buf_idx(input logic [11:0] a);
        logic [11:0] r;
        r = a - cbf_pkg::BUF_BASE;
        return r[8:6];
    endfunction

    // Offset addresses one of the eight data bytes
    function automatic logic data_hit(input logic [5:0] off);
        return (off >= cbf_pkg::BOFF_DATA0) && (off <= cbf_pkg::BOFF_DATA7);
    endfunction

    // Data byte number from a buffer offset
    function automatic logic [2:0] data_slot(input logic [5:0] off);
        logic [5:0] s;
        s = off - cbf_pkg::BOFF_DATA0;
        return s[4:2];
    endfunction

    // [RL7] Length code to byte count, reserved codes give eight
    function automatic logic [3:0] dlc_bytes(input logic [3:0] d);
        return (d > cbf_pkg::DLC_MAX) ? cbf_pkg::DLC_MAX : d;
    endfunction

    cbf_ahb_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // [RL2] Buffer registers present in modes 1 and 2
    wire mode_ok = (mode != cbf_pkg::CBF_MODE0);

    cbf_filter_bank u_filters (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode_ok(mode_ok),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .frame_extended(rx_extended),
        .rd_hit(f_hit),
        .rd_byte(f_byte),
        .filt_ext_sel(filt_ext_sel),
        .filt_present(filt_present),
        .filt_type_ok(filt_type_ok)
    );

    // Write side decode
    wire [2:0] w_buf = buf_idx(wr_addr);
    wire [5:0] w_off = wr_addr[5:0];
    wire w_hit = wr_en && mode_ok && buf_hit(wr_addr);
    // [RL3] [RL4] [RL17] Writes only to idle transmit buffers
    wire w_open = buffer_tx_direction_bits[w_buf] && !transmit_request[w_buf] && !tx_busy[w_buf];
    wire sw_buf_wr = w_hit && w_open;
    wire ctrl_wr = w_hit && (w_off == cbf_pkg::BOFF_CTRL) && buffer_tx_direction_bits[w_buf];

    // Receive capture only into receive-mode buffers
    wire rx_ok = rx_buf < 3'(cbf_pkg::NUM_BUF);
    wire rx_take = rx_store && mode_ok && rx_ok && !buffer_tx_direction_bits[rx_buf];

    // Mode register, reserved mode code ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= cbf_pkg::CBF_MODE0;
        end else if (wr_en && wr_addr == cbf_pkg::OFF_MODE && wr_data[1:0] != 2'b11) begin
            mode <= cbf_pkg::cbf_mode_e'(wr_data[1:0]);
        end
    end

    // [RL1] Buffer direction select register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buffer_tx_direction_bits <= cbf_pkg::BSEL_RESET;
        end else if (wr_en && wr_addr == cbf_pkg::OFF_BSEL) begin
            buffer_tx_direction_bits <= wr_data[7:cbf_pkg::BSEL_DIR_LSB];
        end
    end

    // Request flags: software write beats completion
    always_comb begin
        for (int n = 0; n < cbf_pkg::NUM_BUF; n++) begin
            if (!buffer_tx_direction_bits[n] || !mode_ok) begin
                next_transmit_request[n] = 1'b0;
            end else if (ctrl_wr && w_buf == 3'(n)) begin
                next_transmit_request[n] = wr_data[cbf_pkg::CTRL_REQ_BIT];
            end else if (tx_done[n]) begin
                next_transmit_request[n] = 1'b0;
            end else begin
                next_transmit_request[n] = transmit_request[n];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transmit_request <= 6'h00;
        end else begin
            transmit_request <= next_transmit_request;
        end
    end

    // [RL18] Buffer storage from receiver and software
    always_ff @(posedge hclk) begin
        // [RL5] [RL16] Received frame capture
        if (rx_take) begin
            buf_eid_hi[rx_buf] <= rx_ext_id[15:8];
            buf_eid_lo[rx_buf] <= rx_ext_id[7:0];
            for (int k = 0; k < cbf_pkg::NUM_DATA; k++) begin
                buf_data[rx_buf][k] <= rx_data[8*k +: 8];
            end
            buf_dlc[rx_buf] <= rx_dlc;
            buf_remote[rx_buf] <= rx_remote;
            buf_extended[rx_buf] <= rx_extended;
        end
        // [RL4] Identifier bytes
        if (sw_buf_wr && w_off == cbf_pkg::BOFF_EIDH) buf_eid_hi[w_buf] <= wr_data;
        if (sw_buf_wr && w_off == cbf_pkg::BOFF_EIDL) buf_eid_lo[w_buf] <= wr_data;
        // [RL3] Data bytes
        if (sw_buf_wr && data_hit(w_off)) buf_data[w_buf][data_slot(w_off)] <= wr_data;
        // [RL8] [RL9] Only remote and length code stored
        if (sw_buf_wr && w_off == cbf_pkg::BOFF_LEN) begin
            buf_remote[w_buf] <= wr_data[cbf_pkg::LEN_REMOTE_BIT];
            buf_dlc[w_buf] <= wr_data[3:0];
        end
        // [RL16] Extended frame flag
        if (sw_buf_wr && w_off == cbf_pkg::BOFF_CTRL) begin
            buf_extended[w_buf] <= wr_data[cbf_pkg::CTRL_EXT_BIT];
        end
    end

    // Read side decode
    wire [2:0] r_buf = buf_idx(rd_addr);
    wire [5:0] r_off = rd_addr[5:0];
    wire r_hit = mode_ok && buf_hit(rd_addr);
    // [RL6] [RL9] Length view, bits 7, 5, 4 zero
    wire [7:0] len_view = {1'b0, buf_remote[r_buf], 2'b00, buf_dlc[r_buf]};
    wire [7:0] ctrl_view = {6'h00, buf_extended[r_buf], transmit_request[r_buf]};
    wire [7:0] r_byte = (r_off == cbf_pkg::BOFF_EIDH) ? buf_eid_hi[r_buf] :
                        (r_off == cbf_pkg::BOFF_EIDL) ? buf_eid_lo[r_buf] :
                        data_hit(r_off) ? buf_data[r_buf][data_slot(r_off)] :
                        (r_off == cbf_pkg::BOFF_LEN) ? len_view :
                        (r_off == cbf_pkg::BOFF_CTRL) ? ctrl_view : 8'h00;

    // [RL1] [RL2] Register read mux, unmapped reads zero
    assign rd_data = (rd_addr == cbf_pkg::OFF_MODE) ? {30'h0, mode} :
                     (rd_addr == cbf_pkg::OFF_BSEL) ? {24'h0, buffer_tx_direction_bits, 2'b00} :
                     r_hit ? {24'h0, r_byte} :
                     f_hit ? {24'h0, f_byte} : 32'h0000_0000;

    // Frame fields of the selected buffer for the transmitter
    wire sel_ok = tx_sel < 3'(cbf_pkg::NUM_BUF);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ext_id <= 16'h0000;
            tx_data <= 64'h0;
            tx_dlc <= 4'h0;
            tx_byte_count <= 4'h0;
            tx_remote <= 1'b0;
            tx_extended <= 1'b0;
        end else if (sel_ok) begin
            tx_ext_id <= {buf_eid_hi[tx_sel], buf_eid_lo[tx_sel]};
            for (int k = 0; k < cbf_pkg::NUM_DATA; k++) begin
                tx_data[8*k +: 8] <= buf_data[tx_sel][k];
            end
            tx_dlc <= buf_dlc[tx_sel];
            // [RL7] Byte count from length code
            tx_byte_count <= dlc_bytes(buf_dlc[tx_sel]);
            // [RL8] Remote flag to outgoing frame
            tx_remote <= buf_remote[tx_sel];
            tx_extended <= buf_extended[tx_sel];
        end
    end

    property p_bsel_view;
        @(posedge hclk) disable iff (!hresetn)
        (rd_addr == cbf_pkg::OFF_BSEL)
            |-> (rd_data[1:0] == 2'b00 && rd_data[7:2] == buffer_tx_direction_bits);
    endproperty
    a_bsel_view: assert property (p_bsel_view) // [RL1]
        else $error("buffer select read wrong");

    property p_mode0_absent;
        @(posedge hclk) disable iff (!hresetn)
        (mode == cbf_pkg::CBF_MODE0 && buf_hit(rd_addr)) |-> (rd_data == 32'h0000_0000);
    endproperty
    a_mode0_absent: assert property (p_mode0_absent) // [RL2]
        else $error("buffer visible in mode 0");

    // Data slot of the write address
    wire [2:0] w_slot = data_slot(w_off);

    property p_write_gate;
        @(posedge hclk) disable iff (!hresetn)
        (w_hit && data_hit(w_off) && !w_open && !rx_take)
            |=> (buf_data[$past(w_buf)][$past(w_slot)] == $past(buf_data[w_buf][w_slot]));
    endproperty
    a_write_gate: assert property (p_write_gate) // [RL3]
        else $error("write into locked buffer");

    property p_rx_remote;
        @(posedge hclk) disable iff (!hresetn)
        (rx_take && rx_buf == tx_sel) ##1 (tx_sel == $past(tx_sel))
            |=> (tx_remote == $past(rx_remote, 2));
    endproperty
    a_rx_remote: assert property (p_rx_remote) // [RL5]
        else $error("received remote flag lost");

    property p_len_zero_bits;
        @(posedge hclk) disable iff (!hresetn)
        (r_hit && r_off == cbf_pkg::BOFF_LEN) |-> (rd_data[7] == 1'b0 && rd_data[5:4] == 2'b00);
    endproperty
    a_len_zero_bits: assert property (p_len_zero_bits) // [RL6]
        else $error("length reserved bits set");

    property p_byte_count;
        @(posedge hclk) disable iff (!hresetn)
        (tx_byte_count <= cbf_pkg::DLC_MAX)
            && ((tx_dlc <= cbf_pkg::DLC_MAX) == (tx_byte_count == tx_dlc));
    endproperty
    a_byte_count: assert property (p_byte_count) // [RL7]
        else $error("byte count mapping wrong");

    property p_tx_remote_write;
        @(posedge hclk) disable iff (!hresetn)
        (sw_buf_wr && w_off == cbf_pkg::BOFF_LEN && w_buf == tx_sel) ##1 (tx_sel == $past(tx_sel))
            |=> (tx_remote == $past(wr_data[6], 2) && tx_dlc == $past(wr_data[3:0], 2));
    endproperty
    a_tx_remote_write: assert property (p_tx_remote_write) // [RL8]
        else $error("transmit length not applied");

    property p_tx_ext_flag;
        @(posedge hclk) disable iff (!hresetn)
        (sw_buf_wr && w_off == cbf_pkg::BOFF_CTRL && w_buf == tx_sel) ##1 (tx_sel == $past(tx_sel))
            |=> (tx_extended == $past(wr_data[cbf_pkg::CTRL_EXT_BIT], 2));
    endproperty
    a_tx_ext_flag: assert property (p_tx_ext_flag) // [RL16]
        else $error("extended frame flag lost");

    property p_pending_locks;
        @(posedge hclk) disable iff (!hresetn)
        (transmit_request[tx_sel] && sel_ok)
            |=> ($stable(tx_ext_id) || !transmit_request[$past(tx_sel)]
                 || tx_sel != $past(tx_sel) || $past(rx_take));
    endproperty
    a_pending_locks: assert property (p_pending_locks) // [RL17]
        else $error("pending buffer changed");
endmodule // cbf_top

/* testbench/cbf_can_node.sv */
// Behavioural model of the CAN node side: frame delivery and transmit status
`timescale 1ns/1ps
module cbf_can_node (
    input wire logic hclk,
    output logic rx_store,
    output logic [2:0] rx_buf,
    output logic [15:0] rx_ext_id,
    output logic [63:0] rx_data,
    output logic [3:0] rx_dlc,
    output logic rx_remote,
    output logic rx_extended,
    output logic [5:0] tx_busy,
    output logic [5:0] tx_done
);
    // Quiet lines at time zero
    initial begin
        {rx_store, rx_buf, rx_ext_id, rx_data, rx_dlc, rx_remote, rx_extended} = '0;
        {tx_busy, tx_done} = '0;
    end

    task automatic deliver(input logic [2:0] b, input logic [15:0] id, input logic [63:0] d,
                           input logic [3:0] dlc, input logic rem, input logic ext);
        @(posedge hclk);
        {rx_store, rx_buf, rx_ext_id, rx_data, rx_dlc, rx_remote, rx_extended} <=
            {1'b1, b, id, d, dlc, rem, ext};
        @(posedge hclk);
        // Released fields show their inverse, except rx_extended which holds
        {rx_store, rx_buf, rx_ext_id, rx_data, rx_dlc, rx_remote} <=
            {1'b0, ~b, ~id, ~d, ~dlc, ~rem};
    endtask

    // Busy while sending, then done pulse
    task automatic send(input int n);
        @(posedge hclk);
        tx_busy[n] <= 1'b1;
        repeat (3) @(posedge hclk);
        tx_busy[n] <= 1'b0;
        tx_done[n] <= 1'b1;
        @(posedge hclk);
        tx_done[n] <= 1'b0;
    endtask
endmodule // cbf_can_node

/* testbench/tb_top.sv */
// Register-level bench for the CAN buffer and filter block
`timescale 1ns/1ps
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, tx_sel, rx_buf;
    logic rx_store, rx_remote, rx_extended, tx_remote, tx_extended;
    logic [15:0] rx_ext_id, tx_ext_id, filt_ext_sel, filt_type_ok;
    logic [63:0] rx_data, tx_data;
    logic [3:0] rx_dlc, tx_dlc, tx_byte_count;
    logic [5:0] tx_busy, tx_done, transmit_request;
    int err_total, total_checks;
    assign hready = hreadyout;

    cbf_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hreadyout, .hresp, .hrdata, .rx_store, .rx_buf, .rx_ext_id, .rx_data, .rx_dlc,
        .rx_remote, .rx_extended, .tx_busy, .tx_done, .tx_sel, .transmit_request, .tx_ext_id,
        .tx_data, .tx_dlc, .tx_byte_count, .tx_remote, .tx_extended, .filt_ext_sel,
        .filt_type_ok);
    cbf_can_node i_node (.hclk, .rx_store, .rx_buf, .rx_ext_id, .rx_data, .rx_dlc, .rx_remote,
        .rx_extended, .tx_busy, .tx_done);

    // Clock, 20 ns period
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Compare one result
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One AHB-Lite single word transfer
    task automatic ahb(input logic w, input logic [11:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic exp_rd(input string nm, input logic [11:0] a, input logic [7:0] e);
        ahb(1'b0, a, 8'h00);
        chk(nm, {56'h0, e}, {32'h0, rd});
    endtask

    function automatic logic [11:0] ba(input int n, input logic [5:0] off);
        return cbf_pkg::BUF_BASE + 12'(n * 64) + {6'h0, off};
    endfunction

    function automatic logic [11:0] fa(input int f, input logic [3:0] off);
        return cbf_pkg::FILT_BASE + 12'(f * 16) + {8'h0, off};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        close_out();
    end

    // Main sequence
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        tx_sel = 3'd7; // No buffer selected
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        exp_rd("bsel_reset", cbf_pkg::OFF_BSEL, 8'h00);
        chk("req_reset", 64'h0, {58'h0, transmit_request});
        chk("hresp", 64'h0, {63'h0, hresp});
        // Mode 0: base filters only
        wr(fa(0, cbf_pkg::FOFF_SIDH), 8'h5a);
        exp_rd("filt0_sidh", fa(0, cbf_pkg::FOFF_SIDH), 8'h5a);
        wr(fa(6, cbf_pkg::FOFF_SIDH), 8'h5a);
        exp_rd("filt6_mode0", fa(6, cbf_pkg::FOFF_SIDH), 8'h00);
        wr(fa(0, cbf_pkg::FOFF_SIDL), 8'hff);
        exp_rd("filt0_sidl", fa(0, cbf_pkg::FOFF_SIDL), 8'heb);
        chk("ext_sel0", 64'h1, {63'h0, filt_ext_sel[0]});
        chk("type_ok_std", 64'h0, {63'h0, filt_type_ok[0]});
        wr(cbf_pkg::OFF_MODE, 8'h01);
        wr(cbf_pkg::OFF_BSEL, 8'hf7);
        exp_rd("bsel", cbf_pkg::OFF_BSEL, 8'hf4);
        // Transmit buffer 0 contents
        for (int m = 0; m < 8; m++) wr(ba(0, cbf_pkg::BOFF_DATA0 + 6'(4 * m)), 8'(8'h10 + m));
        for (int m = 0; m < 8; m++)
            exp_rd("tx_byte", ba(0, cbf_pkg::BOFF_DATA0 + 6'(4 * m)), 8'(8'h10 + m));
        wr(ba(0, cbf_pkg::BOFF_EIDH), 8'ha5);
        wr(ba(0, cbf_pkg::BOFF_EIDL), 8'h3c);
        exp_rd("tx_eidh", ba(0, cbf_pkg::BOFF_EIDH), 8'ha5);
        // Every length code, remote bit alternating
        for (int c = 0; c < 16; c++) begin
            wr(ba(0, cbf_pkg::BOFF_LEN), {1'b1, c[0], 2'b11, 4'(c)});
            tx_sel <= 3'd0;
            exp_rd("tx_len", ba(0, cbf_pkg::BOFF_LEN), {1'b0, c[0], 2'b00, 4'(c)});
            repeat (2) @(posedge hclk);
            chk("tx_dlc", 64'(c), {60'h0, tx_dlc});
            chk("tx_count", (c > 8) ? 64'h8 : 64'(c), {60'h0, tx_byte_count});
            chk("tx_remote", 64'(c % 2), {63'h0, tx_remote});
        end
        chk("tx_data", 64'h1716151413121110, tx_data);
        chk("tx_id", 64'ha53c, {48'h0, tx_ext_id});
        // Pending request locks the buffer
        wr(ba(0, cbf_pkg::BOFF_CTRL), 8'h03);
        wr(ba(0, cbf_pkg::BOFF_EIDH), 8'h00);
        exp_rd("locked_eidh", ba(0, cbf_pkg::BOFF_EIDH), 8'ha5);
        chk("req_set", 64'h1, {63'h0, transmit_request[0]});
        chk("tx_ext_flag", 64'h1, {63'h0, tx_extended});
        i_node.send(0);
        @(posedge hclk);
        chk("req_done", 64'h0, {63'h0, transmit_request[0]});
        // Receive buffer 1
        i_node.deliver(3'd1, 16'hbeef, 64'h8877665544332211, 4'h5, 1'b1, 1'b1);
        tx_sel <= 3'd1;
        exp_rd("rx_len", ba(1, cbf_pkg::BOFF_LEN), 8'h45);
        chk("rx_remote_set", 64'h1, {63'h0, tx_remote});
        chk("rx_ext_flag", 64'h1, {63'h0, tx_extended});
        exp_rd("rx_eidl", ba(1, cbf_pkg::BOFF_EIDL), 8'hef);
        chk("type_ok_ext", 64'h1, {63'h0, filt_type_ok[0]});
        wr(ba(1, cbf_pkg::BOFF_DATA7), 8'h00);
        exp_rd("rx_byte7", ba(1, cbf_pkg::BOFF_DATA7), 8'h88);
        wr(ba(1, cbf_pkg::BOFF_EIDH), 8'h00);
        exp_rd("rx_eidh", ba(1, cbf_pkg::BOFF_EIDH), 8'hbe);
        i_node.deliver(3'd1, 16'h1234, 64'h0, 4'h8, 1'b0, 1'b0);
        exp_rd("rx_len_data", ba(1, cbf_pkg::BOFF_LEN), 8'h08);
        chk("rx_remote_clr", 64'h0, {63'h0, tx_remote});
        // Upper filters in mode 1
        wr(fa(7, cbf_pkg::FOFF_EIDH), 8'h96);
        exp_rd("filt7_eidh", fa(7, cbf_pkg::FOFF_EIDH), 8'h96);
        wr(fa(7, cbf_pkg::FOFF_SIDH), 8'h69);
        exp_rd("filt7_sidh", fa(7, cbf_pkg::FOFF_SIDH), 8'h69);
        exp_rd("unmapped", 12'h800, 8'h00);
        // Buffers absent in mode 0
        wr(cbf_pkg::OFF_MODE, 8'h00);
        wr(ba(0, cbf_pkg::BOFF_EIDH), 8'h11);
        wr(cbf_pkg::OFF_MODE, 8'h01);
        exp_rd("mode0_eidh", ba(0, cbf_pkg::BOFF_EIDH), 8'ha5);
        wr(cbf_pkg::OFF_MODE, 8'h02);
        exp_rd("mode2_eidh", ba(0, cbf_pkg::BOFF_EIDH), 8'ha5);
        close_out();
    end
endmodule // tb_top
